// ---- verilog/cfg_word_map_pkg.sv ----
// Constants for the configuration word mapper: load word addresses,
// field positions within load words and reset defaults.
// Assumes a 16-bit load word bus with byte-granular word addresses.
package cfg_word_map_pkg;
    // Load word addresses.
    localparam logic [7:0] addr_phy_port1  = 8'h42;
    localparam logic [7:0] addr_phy_port2  = 8'h44;
    localparam logic [7:0] addr_phy_port3  = 8'h46;
    localparam logic [7:0] addr_pic_port0  = 8'h48;
    localparam logic [7:0] addr_pic_port1  = 8'h4a;
    localparam logic [7:0] addr_pic_port2  = 8'h4c;
    localparam logic [7:0] addr_pic_port3  = 8'h4e;
    localparam logic [7:0] addr_pm_port0   = 8'h50;
    localparam logic [7:0] addr_pm_port1   = 8'h52;

    // Reset defaults of the load words.
    localparam logic [15:0] phy_word_default = 16'h101d;
    localparam logic [15:0] pic_word_default = 16'h000f;
    localparam logic [7:0]  pm_low_default   = 8'hff;
    localparam logic [7:0]  pm_high_default  = 8'h00;

    // PHY load word field positions.
    localparam int phy_b_lsb    = 0;
    localparam int phy_b_width  = 5;
    localparam int phy_c_lsb    = 5;
    localparam int phy_c_width  = 7;
    localparam int deemph_bit   = 12;
    localparam int comp_det_bit = 13;
    localparam int dccs_lsb     = 14;

    // Power-management load word field positions.
    localparam int nsr_bit      = 0;
    localparam int aux_lsb      = 1;
    localparam int d1_bit       = 4;
    localparam int d2_bit       = 5;
    localparam int pme_lsb      = 6;
    localparam int pm_data_lsb  = 8;
endpackage

// ---- verilog/eeprom_config_word_mapper.sv ----
// Maps 16-bit configuration load words into per-port register fields.
// Assumes the loader presents one word with a one-cycle write strobe;
// the serial memory protocol is handled elsewhere.
// Functional notes
// - Port 1 word: bits 12, 13 and 15:14 mapped
// - Word 44h: port 2, bits 4:0 to tuning
// - Port 2 remaining fields split across registers
// - Word 46h: same split for port 3
// - Words 48h-4Eh fill control upper halves
// - Word 50h: port 0 soft reset, aux current
// - Bits 4,5 give D1/D2 support bits
// - Bits 7:6 give PME support D1/D2
// - High byte gives read-only PM data
// - Word 52h: same split for port 1
`timescale 1ns/10ps

module eeprom_config_word_mapper
    import cfg_word_map_pkg::*;
(
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        reset_n,
    // Load word input from the loader.
    input  wire logic        word_write,
    input  wire logic [7:0]  word_addr,
    input  wire logic [15:0] word_data,
    // PHY tuning outputs, ports 1 to 3 (index 0 unused by this block).
    output logic [4:0]       phy_tuning_field_b_p2,
    output logic [4:0]       phy_tuning_field_b_p3,
    output logic [6:0]       phy_tuning_field_c_p2,
    output logic [6:0]       phy_tuning_field_c_p3,
    output logic [3:1]       deemph_select,
    output logic [3:1]       compliance_to_detect,
    output logic [1:0]       data_change_count_select_p1,
    output logic [1:0]       data_change_count_select_p2,
    output logic [1:0]       data_change_count_select_p3,
    // Upper halves of the PHY interface control word, per port.
    output logic [15:0]      phy_interface_control_word_p0,
    output logic [15:0]      phy_interface_control_word_p1,
    output logic [15:0]      phy_interface_control_word_p2,
    output logic [15:0]      phy_interface_control_word_p3,
    // Power-management fields, ports 0 and 1.
    output logic [1:0]       no_soft_reset,
    output logic [2:0]       aux_current_p0,
    output logic [2:0]       aux_current_p1,
    output logic [1:0]       d1_support,
    output logic [1:0]       d2_support,
    output logic [1:0]       pme_support_p0,
    output logic [1:0]       pme_support_p1,
    output logic [7:0]       pm_data_p0,
    output logic [7:0]       pm_data_p1
);

    // ********************************************************
    // Word storage
    // ********************************************************

    // Whole load words are kept; every output bit is taken from one of them,
    // so each output comes straight from a flip-flop with no logic after it.
    // Keeping whole words costs a few flip-flops for bits that no output
    // uses, but puts the whole word-to-field map in one place below.
    //
    // PHY load word, one each for ports 1 to 3:
    //   bits 4:0    tuning field b
    //   bits 11:5   tuning field c
    //   bit 12      de-emphasis select
    //   bit 13      compliance to detect
    //   bits 15:14  data change count select
    //
    // Power-management load word, one each for ports 0 and 1:
    //   bit 0       no soft reset
    //   bits 3:1    auxiliary current
    //   bit 4       D1 support
    //   bit 5       D2 support
    //   bits 7:6    PME support in D1 and D2
    //   bits 15:8   power-management data byte
    //
    // The control words pass all 16 bits through unchanged.
    // Port 1 has no tuning outputs here, so bits 11:0 of its PHY word
    // are stored but unused; they only keep the word handling uniform.

    // ********************************************************
    // Address decode
    // ********************************************************

    // One hit line per load word; a hit needs the strobe and an exact
    // address match, so writes to any other address leave no trace.
    logic       hit_phy_p1;
    logic       hit_phy_p2;
    logic       hit_phy_p3;
    logic [3:0] hit_pic;
    logic       hit_pm_p0;
    logic       hit_pm_p1;

    // The decode is combinational; the words are captured at the edge
    // that samples the strobe, so a field follows its word one cycle on.
    always_comb
    begin
        hit_phy_p1 = word_write && (word_addr == addr_phy_port1);
        hit_phy_p2 = word_write && (word_addr == addr_phy_port2);
        hit_phy_p3 = word_write && (word_addr == addr_phy_port3);
        hit_pic[0] = word_write && (word_addr == addr_pic_port0);
        hit_pic[1] = word_write && (word_addr == addr_pic_port1);
        hit_pic[2] = word_write && (word_addr == addr_pic_port2);
        hit_pic[3] = word_write && (word_addr == addr_pic_port3);
        hit_pm_p0  = word_write && (word_addr == addr_pm_port0);
        hit_pm_p1  = word_write && (word_addr == addr_pm_port1);
    end

    // ********************************************************
    // PHY load words, ports 1 to 3
    // ********************************************************

    // Stored PHY words and their next values.
    logic [15:0] phy_word      [1:3];
    logic [15:0] next_phy_word [1:3];

    // A hit replaces the whole word and anything else holds it, so a
    // rewrite of the same address simply wins over the earlier load.
    always_comb
    begin
        next_phy_word = phy_word;
        if (hit_phy_p1)
        begin
            next_phy_word[1] = word_data;
        end
        if (hit_phy_p2)
        begin
            next_phy_word[2] = word_data;
        end
        if (hit_phy_p3)
        begin
            next_phy_word[3] = word_data;
        end
    end

    // Reset restores the default word, and with it the default of every
    // field split from that word.
    // Defaults until loaded.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            for (int i = 1; i <= 3; i++)
            begin
                phy_word[i] <= phy_word_default;
            end
        end
        else
        begin
            phy_word <= next_phy_word;
        end
    end

    // ********************************************************
    // PHY interface control words, ports 0 to 3
    // ********************************************************

    // Stored upper halves and their next values.
    logic [15:0] pic_word      [0:3];
    logic [15:0] next_pic_word [0:3];

    // The four words share one decode loop; each one only moves on its
    // own hit, so loading one port never disturbs the others.
    always_comb
    begin
        next_pic_word = pic_word;
        for (int p = 0; p <= 3; p++)
        begin
            if (hit_pic[p])
            begin
                next_pic_word[p] = word_data;
            end
        end
    end

    // Reset restores the default upper half of every port.
    // Defaults until loaded.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            for (int i = 0; i <= 3; i++)
            begin
                pic_word[i] <= pic_word_default;
            end
        end
        else
        begin
            pic_word <= next_pic_word;
        end
    end

    // ********************************************************
    // Power-management load words, ports 0 and 1
    // ********************************************************

    // Stored power words and their next values.
    logic [15:0] pm_word      [0:1];
    logic [15:0] next_pm_word [0:1];

    // Same pattern as the PHY words: a hit replaces, anything else holds.
    always_comb
    begin
        next_pm_word = pm_word;
        if (hit_pm_p0)
        begin
            next_pm_word[0] = word_data;
        end
        if (hit_pm_p1)
        begin
            next_pm_word[1] = word_data;
        end
    end

    // The low byte resets to all ones and the high byte to zero, so an
    // unloaded port advertises every capability with an empty data byte.
    // Defaults until loaded.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            for (int i = 0; i <= 1; i++)
            begin
                pm_word[i] <= {pm_high_default, pm_low_default};
            end
        end
        else
        begin
            pm_word <= next_pm_word;
        end
    end

    // ********************************************************
    // Port 0 fields
    // ********************************************************

    assign phy_interface_control_word_p0 = pic_word[0];

    // Software sees the capability and data fields as read-only; only a
    // new load word can change them, and only until the next reset.
    // Reset flag, aux current.
    assign no_soft_reset[0] = pm_word[0][nsr_bit];
    assign aux_current_p0   = pm_word[0][aux_lsb +: 3];
    assign d1_support[0] = pm_word[0][d1_bit];
    assign d2_support[0] = pm_word[0][d2_bit];
    assign pme_support_p0 = pm_word[0][pme_lsb +: 2];
    assign pm_data_p0 = pm_word[0][pm_data_lsb +: 8];

    // ********************************************************
    // Port 1 fields
    // ********************************************************

    assign compliance_to_detect[1]     = phy_word[1][comp_det_bit];
    assign data_change_count_select_p1 = phy_word[1][dccs_lsb +: 2];
    // The de-emphasis bit of the same word.
    assign deemph_select[1]            = phy_word[1][deemph_bit];

    assign phy_interface_control_word_p1 = pic_word[1];

    assign no_soft_reset[1] = pm_word[1][nsr_bit];
    assign aux_current_p1   = pm_word[1][aux_lsb +: 3];
    assign d1_support[1]    = pm_word[1][d1_bit];
    assign d2_support[1]    = pm_word[1][d2_bit];
    assign pme_support_p1   = pm_word[1][pme_lsb +: 2];
    assign pm_data_p1       = pm_word[1][pm_data_lsb +: 8];

    // ********************************************************
    // Port 2 fields
    // ********************************************************

    assign phy_tuning_field_b_p2 = phy_word[2][phy_b_lsb +: phy_b_width];
    assign phy_tuning_field_c_p2       = phy_word[2][phy_c_lsb +: phy_c_width];
    assign deemph_select[2]            = phy_word[2][deemph_bit];
    assign compliance_to_detect[2]     = phy_word[2][comp_det_bit];
    assign data_change_count_select_p2 = phy_word[2][dccs_lsb +: 2];

    assign phy_interface_control_word_p2 = pic_word[2];

    // ********************************************************
    // Port 3 fields
    // ********************************************************

    assign phy_tuning_field_b_p3       = phy_word[3][phy_b_lsb +: phy_b_width];
    assign phy_tuning_field_c_p3       = phy_word[3][phy_c_lsb +: phy_c_width];
    assign deemph_select[3]            = phy_word[3][deemph_bit];
    assign compliance_to_detect[3]     = phy_word[3][comp_det_bit];
    assign data_change_count_select_p3 = phy_word[3][dccs_lsb +: 2];

    assign phy_interface_control_word_p3 = pic_word[3];

endmodule

// ---- verification/eeprom_config_word_mapper_properties.sv ----
// Checker for the configuration word mapper, bound to its top module.
// Assumes one word per word_write pulse and a one-cycle write latency.
`timescale 1ns/10ps
module eeprom_config_word_mapper_properties (
    // Clock, reset and the load word port.
    input logic        clk,
    input logic        reset_n,
    input logic        word_write,
    input logic [7:0]  word_addr,
    input logic [15:0] word_data,
    // PHY fields watched.
    input logic [4:0]  phy_tuning_field_b_p2,
    input logic [4:0]  phy_tuning_field_b_p3,
    input logic [6:0]  phy_tuning_field_c_p2,
    input logic [3:1]  deemph_select,
    input logic [3:1]  compliance_to_detect,
    input logic [1:0]  data_change_count_select_p1,
    input logic [1:0]  data_change_count_select_p2,
    // Control halves watched.
    input logic [15:0] phy_interface_control_word_p0,
    input logic [15:0] phy_interface_control_word_p3,
    // Power-management fields watched.
    input logic [1:0]  no_soft_reset,
    input logic [1:0]  d1_support,
    input logic [1:0]  d2_support,
    input logic [1:0]  pme_support_p1,
    input logic [2:0]  aux_current_p0,
    input logic [7:0]  pm_data_p1
);
    // Every check is sampled on clk and idle while reset is held.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    chk_p2_tuning: assert property (word_write && word_addr == 8'h44 |=>
        {phy_tuning_field_c_p2, phy_tuning_field_b_p2} == $past(word_data[11:0]))
        else $error("port 2 tuning fields wrong");
    chk_p2_flags: assert property (word_write && word_addr == 8'h44 |=>
        {data_change_count_select_p2, compliance_to_detect[2], deemph_select[2]}
        == $past(word_data[15:12])) else $error("port 2 flag fields wrong");
    chk_p3_tuning: assert property (word_write && word_addr == 8'h46 |=>
        phy_tuning_field_b_p3 == $past(word_data[4:0])) else $error("port 3 tuning wrong");
    chk_ctl_load: assert property (word_write && word_addr == 8'h48 |=>
        phy_interface_control_word_p0 == $past(word_data)) else $error("port 0 control wrong");
    chk_ctl_hold: assert property (!(word_write && word_addr == 8'h4e) |=>
        $stable(phy_interface_control_word_p3)) else $error("port 3 control moved");
    chk_nsr_aux: assert property (word_write && word_addr == 8'h50 |=>
        {aux_current_p0, no_soft_reset[0]} == $past(word_data[3:0]))
        else $error("port 0 reset or aux wrong");
    chk_pm_caps: assert property (word_write && word_addr == 8'h50 |=>
        {d2_support[0], d1_support[0]} == $past(word_data[5:4])) else $error("D1 D2 wrong");
    chk_pm_data: assert property (word_write && word_addr == 8'h52 |=>
        {pm_data_p1, pme_support_p1} == $past(word_data[15:6])) else $error("port 1 PM wrong");
    chk_p1_flags: assert property (word_write && word_addr == 8'h42 |=>
        {data_change_count_select_p1, compliance_to_detect[1]} == $past(word_data[15:13]))
        else $error("port 1 PHY flags wrong");
    // Main traffic: each word family is loaded at least once.
    cov_p1: cover property (word_write && word_addr == 8'h42);
    cov_phy: cover property (word_write && word_addr == 8'h44);
    cov_ctl: cover property (word_write && word_addr == 8'h4e);
    cov_pm: cover property (word_write && word_addr == 8'h52);
endmodule
bind eeprom_config_word_mapper eeprom_config_word_mapper_properties chk_u (.*);

// ---- verification/cfg_memory_model.sv ----
// Serial configuration memory seen as a stream of load words 40h to 56h.
// Assumes the bench fills mem and calls send; gap sets idle cycles.
`timescale 1ns/10ps
module cfg_memory_model (
    input  wire logic  clk,
    output logic       word_write,
    output logic [7:0] word_addr,
    output logic [15:0] word_data
);
    logic [15:0] mem [12];
    // Idle bus; words outside 42h..52h are sent too, to be ignored.
    initial
    begin
        word_write = 1'b0;
        word_addr  = 8'h40;
        word_data  = 16'h0000;
    end
    // With a nonzero gap, released data shows the inverse, so stale values never look valid.
    task automatic send(input int gap);
        for (int i = 0; i < 12; i++)
        begin
            @(posedge clk); #1;
            word_write = 1'b1;
            word_addr  = 8'(8'h40 + 2 * i);
            word_data  = mem[i];
            if (gap != 0)
            begin
                @(posedge clk); #1;
                word_write = 1'b0;
                word_data  = ~word_data;
                repeat (gap - 1) @(posedge clk);
            end
        end
        @(posedge clk); #1;
        word_write = 1'b0;
    endtask
endmodule

// ---- verification/eeprom_config_word_mapper_tb.sv ----
// Self-checking bench: defaults, prompt and slow loads, rewrite, reset.
// Assumes the memory model drives every word input of the mapper.
`timescale 1ns/10ps
module eeprom_config_word_mapper_tb;
    import cfg_word_map_pkg::*;
    logic clk, reset_n, word_write;
    logic [7:0] word_addr, pm_data_p0, pm_data_p1;
    logic [15:0] word_data, phy_interface_control_word_p0, phy_interface_control_word_p1;
    logic [15:0] phy_interface_control_word_p2, phy_interface_control_word_p3;
    logic [4:0] phy_tuning_field_b_p2, phy_tuning_field_b_p3;
    logic [6:0] phy_tuning_field_c_p2, phy_tuning_field_c_p3;
    logic [3:1] deemph_select, compliance_to_detect;
    logic [1:0] data_change_count_select_p1, data_change_count_select_p2;
    logic [1:0] data_change_count_select_p3, no_soft_reset, d1_support, d2_support;
    logic [1:0] pme_support_p0, pme_support_p1;
    logic [2:0] aux_current_p0, aux_current_p1;
    logic [15:0] img [12];
    int err_count = 0;
    int n_checks = 0;
    eeprom_config_word_mapper dut_u (.*);
    cfg_memory_model m_u (.clk(clk), .word_write(word_write), .word_addr(word_addr),
        .word_data(word_data));
    // 200 MHz clock.
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic cmp(string n, logic [15:0] seen, logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", n, exp, seen);
        end
    endtask
    // Compares every mapped field against the word image it came from.
    task automatic check_image();
        cmp("p1",
            {data_change_count_select_p1, compliance_to_detect[1], deemph_select[1]},
            {12'h000, img[1][15:12]});
        cmp("p2",
            {data_change_count_select_p2, compliance_to_detect[2], deemph_select[2],
            phy_tuning_field_c_p2, phy_tuning_field_b_p2}, img[2]);
        cmp("p3",
            {data_change_count_select_p3, compliance_to_detect[3], deemph_select[3],
            phy_tuning_field_c_p3, phy_tuning_field_b_p3}, img[3]);
        cmp("c0", phy_interface_control_word_p0, img[4]);
        cmp("c1", phy_interface_control_word_p1, img[5]);
        cmp("c2", phy_interface_control_word_p2, img[6]);
        cmp("c3", phy_interface_control_word_p3, img[7]);
        cmp("pm0",
            {pm_data_p0, pme_support_p0, d2_support[0], d1_support[0], aux_current_p0,
            no_soft_reset[0]}, img[8]);
        cmp("pm1",
            {pm_data_p1, pme_support_p1, d2_support[1], d1_support[1], aux_current_p1,
            no_soft_reset[1]}, img[9]);
    endtask
    // Reset for 16 cycles, then every field must show its default.
    task automatic t_reset();
        reset_n = 1'b0;
        repeat (16) @(posedge clk);
        #1 reset_n = 1'b1;
        img = '{16'h0, 16'h101d, 16'h101d, 16'h101d, 16'h000f, 16'h000f, 16'h000f, 16'h000f,
            16'h00ff, 16'h00ff, 16'h0, 16'h0};
        check_image();
    endtask
    // Loads an image with the given spacing; later loads overwrite earlier ones.
    task automatic t_load(logic [15:0] base, int gap);
        for (int i = 0; i < 12; i++)
            img[i] = base + 16'h1357 * 16'(i);
        m_u.mem = img;
        m_u.send(gap);
        check_image();
    endtask
    task automatic test_done();
        if (err_count == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Main sequence.
    initial
    begin
        t_reset();
        t_load(16'h5a3c, 0);
        t_load(16'ha5c3, 3);
        t_reset();
        t_load(16'h0ff0, 1);
        test_done();
    end
    // Watchdog well beyond the roughly 120 cycles the run needs.
    initial
    begin
        #100000;
        err_count++;
        test_done();
    end
endmodule
